// ==== verilog/pmwc_pkg.sv ====
// Constants and types for the power mode and wake control block
//
// How it works
// - Writing 1 to power control bit 0 halts the core in idle; reads 0.
// - Writing 1 to power control bit 1 places the core in stop; reads 0.
// - Power control bits 7..2 are six plain firmware flags, reset to 0.
// - Wake config bit 7 enters sleep, bit 6 suspend; same write sets enables.
// - Wake config bit 4 is set by hardware on a reset pin glitch.
// - Bit 3 reads the clock fail flag; writing 1 enables that wake source.
// - Bit 2 reads the alarm flag; writing 1 enables alarm wake.
// - Bit 1 reads the pin match flag; writing 1 enables pin match wake.
// - Bit 0 reads the comparator rising edge flag; writing 1 enables it.
// - Writing 1 to wake config bit 5 clears every wake flag except one whose event lands in that cycle.
// - Any wake flag set refuses suspend or sleep and keeps low-power oscillator on.
// - For two clocks after waking from suspend all wake flags read 0.
// - Wake flags follow their events always, enabled or not, also after waking.
// - A reset pin falling edge always wakes the device from sleep.
// - Leaving suspend resumes at the next instruction unless a reset ended it.
package pmwc_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] POWER_CONTROL_ADDR      = 8'h87;
  localparam logic [7:0] WAKE_CONFIGURATION_ADDR = 8'hb5;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int PC_IDLE_BIT      = 0;
  localparam int PC_STOP_BIT      = 1;
  localparam int PC_FLAG_LSB      = 2;
  localparam int PC_FLAG_MSB      = 7;
  localparam int WC_SLEEP_BIT     = 7;
  localparam int WC_SUSPEND_BIT   = 6;
  localparam int WC_CLEAR_BIT     = 5;
  localparam int WC_RESET_PIN_BIT = 4;
  localparam int WC_ENABLE_MSB    = 3;
  localparam int WAKE_COUNT       = 5;
  localparam int SOURCE_COUNT     = 4;

  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [5:0] GENERAL_FLAGS_RST  = 6'h00;
  localparam logic [3:0] WAKE_ENABLE_RST    = 4'h0;
  localparam logic [4:0] WAKE_FLAGS_RST     = 5'h00;
  localparam logic [4:0] EVENT_IDLE_LEVEL   = 5'h10;
  localparam logic [7:0] READ_DATA_RST      = 8'h00;
  localparam logic [1:0] WAKE_SETTLE_CYCLES = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } pmwc_sfr_req_type;

  // Bit order matches the wake flag positions
  typedef struct packed {
    logic reset_pin_n;
    logic clock_fail;
    logic alarm;
    logic pin_match;
    logic comparator;
  } pmwc_event_type;

  typedef struct packed {
    logic idle;
    logic stop;
    logic suspend;
    logic sleep;
  } pmwc_mode_type;

  typedef enum logic [2:0] {
    MODE_RUN,
    MODE_IDLE,
    MODE_STOP,
    MODE_SUSPEND,
    MODE_SLEEP,
    MODE_SETTLE
  } pmwc_state_type;

endpackage : pmwc_pkg

// ==== verilog/pmwc_sync.sv ====
// Two-stage synchroniser for the wake event inputs
`timescale 1ns/1ps
module pmwc_sync (
  // Clock and reset
  input  wire  logic                               clk_in,
  input  wire  logic                               sys_rst_in,
  // Asynchronous levels in, synchronised levels out
  input  wire  logic [pmwc_pkg::WAKE_COUNT-1:0]    async_in,
  output logic       [pmwc_pkg::WAKE_COUNT-1:0]    sync_out
);

  logic [pmwc_pkg::WAKE_COUNT-1:0] meta_q;
  logic [pmwc_pkg::WAKE_COUNT-1:0] meta_d;
  logic [pmwc_pkg::WAKE_COUNT-1:0] sync_q;
  logic [pmwc_pkg::WAKE_COUNT-1:0] sync_d;

  // ----------------------------------------------------------------
  // Per-bit stages
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < pmwc_pkg::WAKE_COUNT; i = i + 1) begin : g_bit
      always_comb begin
        meta_d[i] = async_in[i];
        sync_d[i] = meta_q[i];
      end
      always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
          meta_q[i] <= pmwc_pkg::EVENT_IDLE_LEVEL[i];
          sync_q[i] <= pmwc_pkg::EVENT_IDLE_LEVEL[i];
        end else begin
          meta_q[i] <= meta_d[i];
          sync_q[i] <= sync_d[i];
        end
      end
    end
  endgenerate

  assign sync_out = sync_q;

endmodule : pmwc_sync

// ==== verilog/pmwc_top.sv ====
// Power mode request, wake source enables and wake flags
`timescale 1ns/1ps
module pmwc_top (
  // Clock and reset
  input  wire  logic                       clk_in,
  input  wire  logic                       sys_rst_in,
  // Special function register access from the core
  input  wire  pmwc_pkg::pmwc_sfr_req_type sfr_req_in,
  output logic [7:0]                       sfr_rdata_out,
  // Interrupt request from the core, ends idle
  input  wire  logic                       irq_in,
  // Wake events from pins and peripherals
  input  wire  pmwc_pkg::pmwc_event_type   wake_event_in,
  // Power mode controls
  output pmwc_pkg::pmwc_mode_type          mode_out,
  output logic                             core_halt_out,
  output logic                             lposc_run_out,
  output logic                             resume_out,
  output logic                             request_refused_out,
  // Firmware flags
  output logic [5:0]                       general_flags_out
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [pmwc_pkg::WAKE_COUNT-1:0]   event_sync;
  logic [pmwc_pkg::WAKE_COUNT-1:0]   event_prev_q;
  logic [pmwc_pkg::WAKE_COUNT-1:0]   event_prev_d;
  logic [pmwc_pkg::WAKE_COUNT-1:0]   event_hit;
  logic [pmwc_pkg::WAKE_COUNT-1:0]   wake_flags_q;
  logic [pmwc_pkg::WAKE_COUNT-1:0]   wake_flags_d;
  logic [pmwc_pkg::SOURCE_COUNT-1:0] wake_enable_q;
  logic [pmwc_pkg::SOURCE_COUNT-1:0] wake_enable_d;
  logic [5:0]                        general_flags_q;
  logic [5:0]                        general_flags_d;
  logic [7:0]                        rdata_q;
  logic [7:0]                        rdata_d;
  logic [1:0]                        settle_cnt_q;
  logic [1:0]                        settle_cnt_d;
  pmwc_pkg::pmwc_state_type          state_q;
  pmwc_pkg::pmwc_state_type          state_d;
  pmwc_pkg::pmwc_mode_type           mode_q;
  pmwc_pkg::pmwc_mode_type           mode_d;
  logic                              halt_q;
  logic                              halt_d;
  logic                              lposc_q;
  logic                              lposc_d;
  logic                              resume_q;
  logic                              resume_d;
  logic                              refused_q;
  logic                              refused_d;
  logic                              pc_write;
  logic                              wc_write;
  logic                              pc_read;
  logic                              wc_read;
  logic                              any_flag;
  logic                              wake_now;
  logic                              clear_req;
  logic                              low_power_req;
  logic [4:0]                        flags_visible;
  logic                              sleep_req;
  logic                              suspend_req;
  logic                              stop_req;
  logic                              idle_req;
  logic                              refuse_req;

  // ----------------------------------------------------------------
  // Event input synchronisation
  // ----------------------------------------------------------------
  pmwc_sync u_sync (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .async_in   (wake_event_in),
    .sync_out   (event_sync)
  );

  // ----------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------
  always_comb begin
    event_prev_d = event_sync;
    event_hit    = '0;
    // Falling edge on the active-low reset pin
    event_hit[pmwc_pkg::WC_RESET_PIN_BIT] = event_prev_q[pmwc_pkg::WC_RESET_PIN_BIT] &
                                            ~event_sync[pmwc_pkg::WC_RESET_PIN_BIT];
    // Rising edges of the four peripheral sources
    event_hit[pmwc_pkg::WC_ENABLE_MSB:0] = event_sync[pmwc_pkg::WC_ENABLE_MSB:0] &
                                           ~event_prev_q[pmwc_pkg::WC_ENABLE_MSB:0];
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      event_prev_q <= pmwc_pkg::EVENT_IDLE_LEVEL;
    end else begin
      event_prev_q <= event_prev_d;
    end
  end

  // ----------------------------------------------------------------
  // Register access decode
  // ----------------------------------------------------------------
  always_comb begin
    pc_write = sfr_req_in.wr && (sfr_req_in.addr == pmwc_pkg::POWER_CONTROL_ADDR);
    wc_write = sfr_req_in.wr && (sfr_req_in.addr == pmwc_pkg::WAKE_CONFIGURATION_ADDR);
    pc_read  = sfr_req_in.rd && (sfr_req_in.addr == pmwc_pkg::POWER_CONTROL_ADDR);
    wc_read  = sfr_req_in.rd && (sfr_req_in.addr == pmwc_pkg::WAKE_CONFIGURATION_ADDR);
    clear_req = wc_write && sfr_req_in.wdata[pmwc_pkg::WC_CLEAR_BIT];
    low_power_req = wc_write && (sfr_req_in.wdata[pmwc_pkg::WC_SLEEP_BIT] ||
                                 sfr_req_in.wdata[pmwc_pkg::WC_SUSPEND_BIT]);
    any_flag = |wake_flags_q;
  end

  // ----------------------------------------------------------------
  // Firmware flags
  // ----------------------------------------------------------------
  always_comb begin
    general_flags_d = general_flags_q;
    if (pc_write) begin
      general_flags_d = sfr_req_in.wdata[pmwc_pkg::PC_FLAG_MSB:pmwc_pkg::PC_FLAG_LSB];
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      general_flags_q <= pmwc_pkg::GENERAL_FLAGS_RST;
    end else begin
      general_flags_q <= general_flags_d;
    end
  end

  // ----------------------------------------------------------------
  // Wake enables and wake flags
  // ----------------------------------------------------------------
  always_comb begin
    wake_enable_d = wake_enable_q;
    wake_flags_d  = wake_flags_q;
    if (wc_write) begin
      // Enables take the low bits of every write, mode request included
      wake_enable_d = sfr_req_in.wdata[pmwc_pkg::WC_ENABLE_MSB:0];
    end
    // Clear and enables of a refused write still act
    if (clear_req) begin
      wake_flags_d = pmwc_pkg::WAKE_FLAGS_RST;
    end
    // Events set flags in every state, enabled or not; set beats clear
    wake_flags_d = wake_flags_d | event_hit;
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wake_enable_q <= pmwc_pkg::WAKE_ENABLE_RST;
      wake_flags_q  <= pmwc_pkg::WAKE_FLAGS_RST;
    end else begin
      wake_enable_q <= wake_enable_d;
      wake_flags_q  <= wake_flags_d;
    end
  end

  // ----------------------------------------------------------------
  // Wake decision
  // ----------------------------------------------------------------
  always_comb begin
    // Only a fresh edge wakes, not a flag already up
    wake_now = (|(event_hit[pmwc_pkg::WC_ENABLE_MSB:0] & wake_enable_q)) ||
               event_hit[pmwc_pkg::WC_RESET_PIN_BIT];
  end

  // ----------------------------------------------------------------
  // Mode request decode
  // ----------------------------------------------------------------
  always_comb begin
    // Flags before this write decide a refusal
    refuse_req  = low_power_req && any_flag;
    sleep_req   = wc_write && sfr_req_in.wdata[pmwc_pkg::WC_SLEEP_BIT];
    suspend_req = wc_write && sfr_req_in.wdata[pmwc_pkg::WC_SUSPEND_BIT];
    stop_req    = pc_write && sfr_req_in.wdata[pmwc_pkg::PC_STOP_BIT];
    idle_req    = pc_write && sfr_req_in.wdata[pmwc_pkg::PC_IDLE_BIT];
  end

  // ----------------------------------------------------------------
  // Power mode sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_d      = state_q;
    settle_cnt_d = settle_cnt_q;
    resume_d     = 1'b0;
    refused_d    = 1'b0;
    unique case (state_q)
      pmwc_pkg::MODE_RUN, pmwc_pkg::MODE_SETTLE: begin
        if (state_q == pmwc_pkg::MODE_SETTLE) begin
          if (settle_cnt_q == 2'h1) begin
            state_d = pmwc_pkg::MODE_RUN;
          end
          settle_cnt_d = settle_cnt_q - 2'h1;
        end
        // Requests taken while settling too; sleep beats suspend, stop beats idle
        if (refuse_req) begin
          refused_d = 1'b1;
        end else if (sleep_req) begin
          state_d = pmwc_pkg::MODE_SLEEP;
        end else if (suspend_req) begin
          state_d = pmwc_pkg::MODE_SUSPEND;
        end else if (stop_req) begin
          state_d = pmwc_pkg::MODE_STOP;
        end else if (idle_req) begin
          state_d = pmwc_pkg::MODE_IDLE;
        end
      end
      pmwc_pkg::MODE_IDLE: begin
        if (irq_in) begin
          state_d  = pmwc_pkg::MODE_RUN;
          resume_d = 1'b1;
        end
      end
      pmwc_pkg::MODE_STOP: begin
        // Only a device reset ends stop
        state_d = pmwc_pkg::MODE_STOP;
      end
      pmwc_pkg::MODE_SUSPEND: begin
        if (wake_now) begin
          state_d      = pmwc_pkg::MODE_SETTLE;
          settle_cnt_d = pmwc_pkg::WAKE_SETTLE_CYCLES;
          resume_d     = 1'b1;
        end
      end
      pmwc_pkg::MODE_SLEEP: begin
        if (wake_now) begin
          state_d  = pmwc_pkg::MODE_RUN;
          resume_d = 1'b1;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Mode outputs
  // ----------------------------------------------------------------
  always_comb begin
    mode_d.idle    = (state_d == pmwc_pkg::MODE_IDLE);
    mode_d.stop    = (state_d == pmwc_pkg::MODE_STOP);
    mode_d.suspend = (state_d == pmwc_pkg::MODE_SUSPEND);
    mode_d.sleep   = (state_d == pmwc_pkg::MODE_SLEEP);
    halt_d = mode_d.idle || mode_d.stop || mode_d.suspend || mode_d.sleep;
    // Low-power oscillator may stop only in suspend or sleep with no flag up
    lposc_d = !(mode_d.suspend || mode_d.sleep) || (|wake_flags_d);
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_q      <= pmwc_pkg::MODE_RUN;
      settle_cnt_q <= '0;
      mode_q       <= '0;
      halt_q       <= 1'b0;
      lposc_q      <= 1'b1;
      resume_q     <= 1'b0;
      refused_q    <= 1'b0;
    end else begin
      state_q      <= state_d;
      settle_cnt_q <= settle_cnt_d;
      mode_q       <= mode_d;
      halt_q       <= halt_d;
      lposc_q      <= lposc_d;
      resume_q     <= resume_d;
      refused_q    <= refused_d;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_comb begin
    // Flags are hidden while the unit settles after suspend
    flags_visible = (state_q == pmwc_pkg::MODE_SETTLE) ? pmwc_pkg::WAKE_FLAGS_RST : wake_flags_q;
    rdata_d = rdata_q;
    if (pc_read) begin
      rdata_d = {general_flags_q, 2'b00};
    end else if (wc_read) begin
      rdata_d = {3'b000, flags_visible};
    end else if (sfr_req_in.rd) begin
      rdata_d = pmwc_pkg::READ_DATA_RST;
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rdata_q <= pmwc_pkg::READ_DATA_RST;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // Output drive
  // ----------------------------------------------------------------
  assign sfr_rdata_out       = rdata_q;
  assign mode_out            = mode_q;
  assign core_halt_out       = halt_q;
  assign lposc_run_out       = lposc_q;
  assign resume_out          = resume_q;
  assign request_refused_out = refused_q;
  assign general_flags_out   = general_flags_q;

endmodule : pmwc_top

// ==== bench/pmwc_top_properties.sv ====
// Concurrent checks on the power mode and wake control ports
`timescale 1ns/1ps
module pmwc_top_checker (
  // Clock and reset
  input  wire logic                       clk_in,
  input  wire logic                       sys_rst_in,
  // Requests and events
  input  wire pmwc_pkg::pmwc_sfr_req_type sfr_req_in,
  input  wire pmwc_pkg::pmwc_event_type   wake_event_in,
  // Block outputs
  input  wire logic [7:0]                 sfr_rdata_out,
  input  wire pmwc_pkg::pmwc_mode_type    mode_out,
  input  wire logic                       core_halt_out,
  input  wire logic                       lposc_run_out,
  input  wire logic                       resume_out,
  input  wire logic                       request_refused_out,
  input  wire logic [5:0]                 general_flags_out
);
  logic       pc_rd;
  logic       pc_wr;
  logic       run;
  logic [5:0] wflags;
  assign pc_rd  = sfr_req_in.rd && (sfr_req_in.addr == pmwc_pkg::POWER_CONTROL_ADDR);
  assign pc_wr  = sfr_req_in.wr && (sfr_req_in.addr == pmwc_pkg::POWER_CONTROL_ADDR);
  assign run    = (mode_out == 4'h0) && !core_halt_out;
  assign wflags = sfr_req_in.wdata[7:2];

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_pc_low;
    pc_rd |=> sfr_rdata_out[1:0] == 2'h0;
  endproperty
  property p_gf_read;
    pc_rd |=> sfr_rdata_out[7:2] == $past(general_flags_out);
  endproperty
  property p_gf_write;
    pc_wr |=> general_flags_out == $past(wflags);
  endproperty
  property p_idle;
    pc_wr && run && sfr_req_in.wdata[1:0] == 2'h1 |=> mode_out == 4'h8 && core_halt_out;
  endproperty
  property p_stop;
    pc_wr && run && sfr_req_in.wdata[1] |=> mode_out == 4'h4 && core_halt_out;
  endproperty
  property p_refuse;
    request_refused_out |-> mode_out == 4'h0 && lposc_run_out;
  endproperty
  property p_lposc;
    !lposc_run_out |-> mode_out.suspend || mode_out.sleep;
  endproperty
  property p_resume;
    resume_out |-> !core_halt_out && mode_out == 4'h0 ##1 !resume_out;
  endproperty
  property p_pin_wake;
    mode_out.sleep && $fell(wake_event_in.reset_pin_n) |-> ##[1:4] (mode_out == 4'h0 && resume_out);
  endproperty

  a_pc_low: assert property (p_pc_low) else $error("mode bits read back nonzero");
  a_gf_read: assert property (p_gf_read) else $error("flag read differs");
  a_gf_write: assert property (p_gf_write) else $error("flag write lost");
  a_idle: assert property (p_idle) else $error("idle not entered");
  a_stop: assert property (p_stop) else $error("stop not entered");
  a_refuse: assert property (p_refuse) else $error("refused request changed mode");
  a_lposc: assert property (p_lposc) else $error("oscillator off outside low power");
  a_resume: assert property (p_resume) else $error("resume pulse wrong");
  a_pin_wake: assert property (p_pin_wake) else $error("reset pin edge did not wake");

  c_idle: cover property (mode_out.idle ##[1:20] resume_out);
  c_wake: cover property (mode_out.suspend ##1 resume_out);
  c_refuse: cover property (request_refused_out);
endmodule : pmwc_top_checker

bind pmwc_top pmwc_top_checker u_chk (
  .clk_in(clk_in), .sys_rst_in(sys_rst_in), .sfr_req_in(sfr_req_in),
  .wake_event_in(wake_event_in), .sfr_rdata_out(sfr_rdata_out), .mode_out(mode_out),
  .core_halt_out(core_halt_out), .lposc_run_out(lposc_run_out), .resume_out(resume_out),
  .request_refused_out(request_refused_out), .general_flags_out(general_flags_out)
);

// ==== bench/pmwc_core_model.sv ====
// Core side model issuing register accesses and interrupts
`timescale 1ns/1ps
module pmwc_core_model (
  // Clock
  input  wire logic                  clk_in,
  // Requests to the block
  output pmwc_pkg::pmwc_sfr_req_type sfr_req_out,
  output logic                       irq_out
);
  initial begin
    sfr_req_out = '0;
    irq_out     = 1'b0;
  end

  // Called at a falling edge; holds one cycle, returns at the next
  task automatic acc(input logic [7:0] a, input logic w, input logic r, input logic [7:0] d);
    sfr_req_out = '{addr: a, wr: w, rd: r, wdata: d};
    @(negedge clk_in);
  endtask : acc
endmodule : pmwc_core_model

// ==== bench/testbench.sv ====
// Self-checking bench for the power mode and wake control block
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module testbench;
  logic                       clk_in;
  logic                       sys_rst_in;
  pmwc_pkg::pmwc_sfr_req_type sfr_req;
  logic                       irq;
  pmwc_pkg::pmwc_event_type   ev;
  logic [7:0]                 sfr_rdata_out;
  pmwc_pkg::pmwc_mode_type    mode_out;
  logic                       core_halt_out;
  logic                       lposc_run_out;
  logic                       resume_out;
  logic                       request_refused_out;
  logic [5:0]                 general_flags_out;
  logic [7:0]                 exp_q[$];
  logic [7:0]                 got_exp;
  logic                       rd_q;
  logic [31:0]                rnd;
  logic [7:0]                 v;
  int                         num_errors;
  int                         checks;
  int                         cycles;
  int                         seed;
  int                         i;

  pmwc_core_model core (.clk_in(clk_in), .sfr_req_out(sfr_req), .irq_out(irq));
  pmwc_top DUT (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .sfr_req_in(sfr_req), .sfr_rdata_out(sfr_rdata_out),
    .irq_in(irq), .wake_event_in(ev), .mode_out(mode_out), .core_halt_out(core_halt_out),
    .lposc_run_out(lposc_run_out), .resume_out(resume_out),
    .request_refused_out(request_refused_out), .general_flags_out(general_flags_out)
  );

  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  // ----------------------------------------------------------------
  // Read data monitor
  // ----------------------------------------------------------------
  always @(posedge clk_in) rd_q <= sfr_req.rd;
  always @(negedge clk_in) begin
    if (rd_q === 1'b1 && exp_q.size() > 0) begin
      got_exp = exp_q.pop_front();
      `CHK(sfr_rdata_out, got_exp)
    end
  end

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      close_out();
    end
  end

  // ----------------------------------------------------------------
  // Tasks; all but close_out entered and left at a falling edge
  // ----------------------------------------------------------------
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    core.acc(a, 1'b0, 1'b1, 8'h00);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    core.acc(a, 1'b1, 1'b0, d);
  endtask : wr

  task automatic nop(input int n);
    repeat (n) core.acc(8'h00, 1'b0, 1'b0, 8'h00);
  endtask : nop

  task automatic wait_resume;
    int n;
    n = 0;
    while (resume_out !== 1'b1 && n < 8) begin
      nop(1);
      n++;
    end
    `CHK(resume_out, 1'b1)
    `CHK(core_halt_out, 1'b0)
  endtask : wait_resume

  task automatic close_out;
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    sys_rst_in = 1'b1;
    ev = pmwc_pkg::EVENT_IDLE_LEVEL;
    seed = 26;
    repeat (20) @(negedge clk_in);
    sys_rst_in = 1'b0;
    nop(3);
    rd(8'h87, 8'h00);
    rd(8'hb5, 8'h00);
    wr(8'hb5, 8'h20);
    rnd = $random(seed);
    v = rnd[7:0] & 8'hfc;
    wr(8'h87, v | 8'h01);
    `CHK(mode_out, 4'h8)
    `CHK(general_flags_out, v[7:2])
    rd(8'h87, v);
    core.irq_out = 1'b1;
    wait_resume();
    core.irq_out = 1'b0;
    `CHK(mode_out, 4'h0)
    rnd = $random(seed);
    v = rnd[7:0] & 8'hfc;
    wr(8'h87, v | 8'h02);
    `CHK(mode_out, 4'h4)
    rd(8'h87, v);
    nop(3);
    `CHK(mode_out, 4'h4)
    sys_rst_in = 1'b1;
    nop(2);
    sys_rst_in = 1'b0;
    `CHK(general_flags_out, 6'h00)
    `CHK(mode_out, 4'h0)
    nop(3);
    for (i = 0; i < 4; i++) begin
      ev[i] = 1'b1;
      nop(4);
      rd(8'hb5, (8'h02 << i) - 8'h01);
    end
    ev[4] = 1'b0;
    nop(4);
    rd(8'hb5, 8'h1f);
    ev = pmwc_pkg::EVENT_IDLE_LEVEL;
    wr(8'hb5, 8'h84);
    `CHK(request_refused_out, 1'b1)
    `CHK(mode_out, 4'h0)
    `CHK(lposc_run_out, 1'b1)
    nop(1);
    `CHK(request_refused_out, 1'b0)
    wr(8'hb5, 8'h20);
    rd(8'hb5, 8'h00);
    wr(8'hb5, 8'h44);
    `CHK(mode_out, 4'h2)
    `CHK(lposc_run_out, 1'b0)
    ev[2] = 1'b1;
    wait_resume();
    `CHK(lposc_run_out, 1'b1)
    rd(8'hb5, 8'h00);
    rd(8'hb5, 8'h00);
    rd(8'hb5, 8'h04);
    ev[2] = 1'b0;
    wr(8'hb5, 8'h20);
    wr(8'hb5, 8'h80);
    `CHK(mode_out, 4'h1)
    ev[0] = 1'b1;
    nop(5);
    `CHK(mode_out, 4'h1)
    `CHK(lposc_run_out, 1'b1)
    ev[4] = 1'b0;
    wait_resume();
    `CHK(mode_out, 4'h0)
    rd(8'hb5, 8'h11);
    ev = pmwc_pkg::EVENT_IDLE_LEVEL;
    nop(3);
    close_out();
  end
endmodule : testbench
